// ---- rac_pkg.sv ----
package rac_pkg;
    // ----------------------------------------
    // apb register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_INDIRECT_ADDR = 8'h00;
    localparam logic [7:0] ADDR_INDIRECT_DATA = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    // ----------------------------------------
    // indirect register map
    // ----------------------------------------
    localparam logic [7:0] IND_SNAP0 = 8'h00;
    localparam logic [7:0] IND_SNAP3 = 8'h03;
    localparam logic [7:0] IND_MATCH0 = 8'h08;
    localparam logic [7:0] IND_MATCH3 = 8'h0B;
    localparam logic [7:0] IND_CONTROL = 8'h04;
    localparam logic [7:0] IND_XTAL_CFG = 8'h05;
    // ----------------------------------------
    // control and crystal config fields
    // ----------------------------------------
    localparam int CTL_ALARM_EN = 0;
    localparam int CTL_AUTO_RST = 1;
    localparam int CTL_CAPTURE = 2;
    localparam int CTL_RUN = 3;
    localparam int CTL_ROUTE_RST = 4;
    localparam int CTL_ROUTE_WAKE = 5;
    localparam int XCF_AUTO_STEP = 4;
    localparam int XCF_SETTLED = 7;
    localparam logic [7:0] CTL_RESET = 8'h08;
    localparam logic [3:0] CAP_MIN = 4'h0;
    // ----------------------------------------
    // interrupt status bits
    // ----------------------------------------
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_SETTLED = 1;
    localparam int IRQ_W = 2;
    // ----------------------------------------
    // cap stepping interval
    // ----------------------------------------
    localparam int STEP_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int STEP_CYC = STEP_NS / CLK_NS;
    localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);
    // ----------------------------------------
    // stepper states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STEP = 3'b010,
        ST_DONE = 3'b100
    } rac_step_t;
endpackage : rac_pkg

// ---- rac_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// How it works
// RULE1: indirect address steps after each snapshot or match byte access, always.
// RULE2: software loads start address once, then data writes with idle gaps.
// RULE3: sixteen load capacitance codes held in a four bit config field.
// RULE4: auto stepping starts at smallest code and rises to the final code.
// RULE5: settled flag goes high once applied code equals final code.
// RULE6: alarm fires only when full 32 bit timer equals match value.
// RULE7: auto reset clears timer one cycle after alarm event.
// RULE8: alarm event can reset, wake or interrupt the processor.
// RULE9: software disables alarm, writes match, then enables alarm.
// RULE10: writing alarm enable to zero clears the alarm event flag.
// RULE11: without auto reset, re-enabling gives next alarm after full wrap.
// RULE12: alarm event flag lasts at most one clock cycle.
module rac_top
    import rac_pkg::*;
(
    input wire logic CLOCK_IN, // block clock
    input wire logic RST_B_IN, // async reset, low
    input wire logic PSEL_IN, // apb select
    input wire logic PENABLE_IN, // apb enable
    input wire logic PWRITE_IN, // apb direction
    input wire logic [7:0] PADDR_IN, // apb byte address
    input wire logic [31:0] PWDATA_IN, // apb write data
    output logic [31:0] PRDATA_OUT, // apb read data
    output logic PREADY_OUT, // apb ready
    output logic PSLVERR_OUT, // apb error
    output logic [3:0] LOAD_CAP_CODE_OUT, // applied cap code
    output logic ALARM_EVENT_FLAG_OUT, // one cycle alarm
    output logic ALARM_RESET_OUT, // alarm routed to reset
    output logic ALARM_WAKE_OUT, // alarm routed to wake
    output logic IRQ_OUT // level interrupt
);
    import rac_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] ind_addr_q, ind_addr_d;
    logic [7:0] ctl_q, ctl_d;
    logic [4:0] xcf_q, xcf_d; // [3:0] final code, [4] auto step
    logic [31:0] timer_q, timer_d;
    logic [31:0] snap_q, snap_d;
    logic [31:0] match_q, match_d;
    logic alarm_q, alarm_d;
    logic clr_pend_q, clr_pend_d;
    logic [3:0] cap_q, cap_d;
    logic [7:0] tick_q, tick_d;
    rac_step_t st_q, st_d;
    logic [IRQ_W-1:0] sts_q, sts_d, msk_q, msk_d;
    logic [31:0] rdata_q, rdata_d;
    logic settled;
    logic hit;

    wire logic acc = PSEL_IN && PENABLE_IN;
    wire logic wr = acc && PWRITE_IN;
    wire logic data_acc = acc && PADDR_IN == ADDR_INDIRECT_DATA;
    wire logic ind_wr = wr && PADDR_IN == ADDR_INDIRECT_DATA;
    wire logic [7:0] wbyte = PWDATA_IN[7:0];
    wire logic in_snap = ind_addr_q >= IND_SNAP0 && ind_addr_q <= IND_SNAP3;
    wire logic in_match = ind_addr_q >= IND_MATCH0 && ind_addr_q <= IND_MATCH3;
    wire logic [1:0] bsel = ind_addr_q[1:0];
    wire logic known = PADDR_IN == ADDR_INDIRECT_ADDR || PADDR_IN == ADDR_INDIRECT_DATA
        || PADDR_IN == ADDR_IRQ_STATUS || PADDR_IN == ADDR_IRQ_MASK;

    // zero wait states; unmapped addresses answer with an error
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = acc && !known;
    assign PRDATA_OUT = rdata_q;

    // ----------------------------------------
    // indirect port and registers
    // ----------------------------------------
    // one process for software-visible state; hardware events win over clears
    always_comb begin
        ind_addr_d = ind_addr_q;
        ctl_d = ctl_q;
        xcf_d = xcf_q;
        snap_d = snap_q;
        match_d = match_q;
        msk_d = msk_q;
        sts_d = sts_q;
        rdata_d = rdata_q;
        if (wr && PADDR_IN == ADDR_INDIRECT_ADDR) begin
            ind_addr_d = wbyte;
        end
        if (wr && PADDR_IN == ADDR_IRQ_MASK) begin
            msk_d = PWDATA_IN[IRQ_W-1:0];
        end
        if (wr && PADDR_IN == ADDR_IRQ_STATUS) begin
            sts_d = sts_q & ~PWDATA_IN[IRQ_W-1:0];
        end
        if (ind_wr) begin
            if (in_match) begin
                match_d[bsel*8 +: 8] = wbyte;
            end else if (ind_addr_q == IND_CONTROL) begin
                ctl_d = wbyte;
                ctl_d[CTL_CAPTURE] = 1'b0; // capture is a strobe
            end else if (ind_addr_q == IND_XTAL_CFG) begin
                xcf_d = wbyte[4:0]; // RULE3
            end
        end
        if (ind_wr && ind_addr_q == IND_CONTROL && wbyte[CTL_CAPTURE]) begin
            snap_d = timer_q;
        end
        // auto-advance cannot be turned off
        if (data_acc && (in_snap || in_match)) begin
            ind_addr_d = ind_addr_q + 8'h01; // RULE1
        end
        // read data is registered in the setup cycle so it stands through the access
        if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            unique case (PADDR_IN)
                ADDR_INDIRECT_ADDR: rdata_d = {24'h000000, ind_addr_q};
                ADDR_IRQ_STATUS: rdata_d = {30'h00000000, sts_q};
                ADDR_IRQ_MASK: rdata_d = {30'h00000000, msk_q};
                ADDR_INDIRECT_DATA: begin
                    if (in_snap) begin
                        rdata_d = {24'h000000, snap_q[bsel*8 +: 8]};
                    end else if (in_match) begin
                        rdata_d = {24'h000000, match_q[bsel*8 +: 8]};
                    end else if (ind_addr_q == IND_CONTROL) begin
                        rdata_d = {24'h000000, ctl_q};
                    end else if (ind_addr_q == IND_XTAL_CFG) begin
                        rdata_d = {24'h000000, settled, 2'b00, xcf_q}; // RULE5
                    end else begin
                        rdata_d = 32'h00000000;
                    end
                end
                default: rdata_d = 32'h00000000;
            endcase
        end
        // sticky event bits, set beats a same-cycle clear
        if (hit) begin
            sts_d[IRQ_ALARM] = 1'b1;
        end
        if (st_q != ST_DONE && st_d == ST_DONE && cap_d == xcf_q[3:0]) begin // RULE5
            sts_d[IRQ_SETTLED] = 1'b1;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ind_addr_q <= 8'h00;
            ctl_q <= CTL_RESET;
            xcf_q <= 5'h00;
            snap_q <= 32'h00000000;
            match_q <= 32'h00000000;
            msk_q <= '0;
            sts_q <= '0;
            rdata_q <= 32'h00000000;
        end else begin
            ind_addr_q <= ind_addr_d;
            ctl_q <= ctl_d;
            xcf_q <= xcf_d;
            snap_q <= snap_d;
            match_q <= match_d;
            msk_q <= msk_d;
            sts_q <= sts_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // timer and alarm
    // ----------------------------------------
    // equality only; without auto reset, a re-enable with same match waits for the timer to wrap
    assign hit = ctl_q[CTL_ALARM_EN] && timer_q == match_q && !alarm_q; // RULE6 RULE11

    always_comb begin
        timer_d = timer_q;
        if (ctl_q[CTL_RUN]) begin
            timer_d = timer_q + 32'h00000001;
        end
        if (clr_pend_q) begin
            timer_d = 32'h00000000; // RULE7
        end
        clr_pend_d = hit && ctl_q[CTL_AUTO_RST];
        // flag lasts one cycle and dies when enable is written low
        alarm_d = hit; // RULE12
        if (!ctl_d[CTL_ALARM_EN]) begin
            alarm_d = 1'b0; // RULE10
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            timer_q <= 32'h00000000;
            clr_pend_q <= 1'b0;
            alarm_q <= 1'b0;
        end else begin
            timer_q <= timer_d;
            clr_pend_q <= clr_pend_d;
            alarm_q <= alarm_d;
        end
    end

    // alarm routing to reset, wake and interrupt
    assign ALARM_EVENT_FLAG_OUT = alarm_q;
    assign ALARM_RESET_OUT = alarm_q && ctl_q[CTL_ROUTE_RST]; // RULE8
    assign ALARM_WAKE_OUT = alarm_q && ctl_q[CTL_ROUTE_WAKE]; // RULE8
    assign IRQ_OUT = |(sts_q & msk_q); // RULE8

    // ----------------------------------------
    // load capacitance stepper
    // ----------------------------------------
    // slow ramp keeps the crystal starting fast on low load
    always_comb begin
        st_d = st_q;
        cap_d = cap_q;
        tick_d = tick_q;
        unique case (st_q)
            ST_IDLE: begin
                cap_d = xcf_q[XCF_AUTO_STEP] ? CAP_MIN : xcf_q[3:0]; // RULE4
                tick_d = 8'h00;
                st_d = xcf_q[XCF_AUTO_STEP] ? ST_STEP : ST_DONE;
            end
            ST_STEP: begin
                if (cap_q >= xcf_q[3:0]) begin
                    st_d = ST_DONE;
                end else if (tick_q == STEP_LAST) begin
                    tick_d = 8'h00;
                    cap_d = cap_q + 4'h1; // RULE4
                end else begin
                    tick_d = tick_q + 8'h01;
                end
            end
            ST_DONE: begin
                // a new final code or mode restarts the ramp
                if (ind_wr && ind_addr_q == IND_XTAL_CFG) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    assign settled = st_q == ST_DONE && cap_q == xcf_q[3:0]; // RULE5
    assign LOAD_CAP_CODE_OUT = cap_q;

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            st_q <= ST_IDLE;
            cap_q <= CAP_MIN;
            tick_q <= 8'h00;
        end else begin
            st_q <= st_d;
            cap_q <= cap_d;
            tick_q <= tick_d;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_hit_auto;
        hit && ctl_q[CTL_AUTO_RST];
    endsequence

    a_addr_advance: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN) // RULE1
        data_acc && (in_snap || in_match) |=> ind_addr_q == $past(ind_addr_q) + 8'h01)
        else $error("indirect address did not advance");
    a_alarm_equal: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN) // RULE6
        alarm_q |-> $past(timer_q) == $past(match_q))
        else $error("alarm without equality");
    a_auto_clear: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN) // RULE7
        s_hit_auto |=> ##1 timer_q == 32'h00000000)
        else $error("timer not cleared after alarm");
    a_flag_short: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN) // RULE12
        alarm_q |=> !alarm_q)
        else $error("alarm flag held too long");
    a_enable_clear: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN) // RULE10
        !ctl_q[CTL_ALARM_EN] |-> !alarm_q)
        else $error("alarm flag while disabled");
    a_route_reset: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN) // RULE8
        ALARM_RESET_OUT |-> alarm_q && ctl_q[CTL_ROUTE_RST])
        else $error("reset route wrong");
    a_step_rise: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN) // RULE4
        st_q == ST_STEP && $past(st_q) == ST_STEP |-> cap_q >= $past(cap_q))
        else $error("cap code fell while stepping");
    a_settled_ok: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN) // RULE5
        settled |-> LOAD_CAP_CODE_OUT == xcf_q[3:0])
        else $error("settled before final code");
endmodule : rac_top
`default_nettype wire

// ---- rac_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module rac_top_tb;
    import rac_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clk;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, flag, a_rst, a_wake, irq;
    logic [3:0] cap, prev;
    logic [31:0] v, t, m;
    logic e;
    int n;
    int err_count = 0;
    int comparisons = 0;

    rac_top rac_top_i (.CLOCK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LOAD_CAP_CODE_OUT(cap),
        .ALARM_EVENT_FLAG_OUT(flag), .ALARM_RESET_OUT(a_rst), .ALARM_WAKE_OUT(a_wake),
        .IRQ_OUT(irq));

    // free running 100 mhz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // verdict and bus tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // one apb transfer; read data and error are taken at the access edge
    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rdat, output logic er);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (pready !== 1'b1) err_count++;
        er = pslverr;
        rdat = is_wr ? 32'h0 : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic x;
        apb(1'b1, a, d, r, x);
        `CHK(x, 1'b0)
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic x;
        apb(1'b0, a, 32'h0, d, x);
    endtask : rd

    // counts settled samples until the alarm pulse shows, bounded
    task automatic wait_flag(input int lim, output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (flag !== 1'b1 && c < lim);
    endtask : wait_flag

    // watchdog well past the expected run of some 15k cycles
    initial begin
        #1000000;
        err_count++;
        tally_and_finish();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        #1;
        `CHK(pready, 1'b1)
        `CHK({irq, flag, cap}, 6'h00)
        @(posedge clk);
        rst_b <= 1'b1;
        // reset values and no advance outside the byte ranges
        rd(ADDR_INDIRECT_ADDR, v);
        `CHK(v[7:0], 8'h00)
        wr(ADDR_INDIRECT_ADDR, {24'h0, IND_CONTROL});
        rd(ADDR_INDIRECT_DATA, v);
        `CHK(v[7:0], CTL_RESET)
        rd(ADDR_INDIRECT_ADDR, v);
        `CHK(v[7:0], IND_CONTROL)
        rd(ADDR_IRQ_MASK, v);
        `CHK(v, 32'h0)
        rd(ADDR_IRQ_STATUS, v);
        `CHK(v, 32'h1 << IRQ_SETTLED)
        // unmapped address is refused
        apb(1'b1, 8'h10, 32'hFFFFFFFF, v, e);
        `CHK(e, 1'b1)
        apb(1'b0, 8'h10, 32'h0, v, e);
        `CHK({e, v}, {1'b1, 32'h0})
        // snapshot the timer with the alarm off, read bytes back
        wr(ADDR_INDIRECT_ADDR, {24'h0, IND_CONTROL});
        wr(ADDR_INDIRECT_DATA, 32'h0C);
        wr(ADDR_INDIRECT_ADDR, {24'h0, IND_SNAP0});
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_INDIRECT_DATA, v);
            t[8*i +: 8] = v[7:0];
        end
        rd(ADDR_INDIRECT_ADDR, v);
        `CHK(v[7:0], IND_SNAP3 + 8'h01)
        // match a little ahead; the write task leaves an idle cycle
        m = t + 32'd600;
        wr(ADDR_INDIRECT_ADDR, {24'h0, IND_MATCH0});
        for (int i = 0; i < 4; i++) wr(ADDR_INDIRECT_DATA, {24'h0, m[8*i +: 8]});
        rd(ADDR_INDIRECT_ADDR, v);
        `CHK(v[7:0], IND_MATCH3 + 8'h01)
        wr(ADDR_INDIRECT_ADDR, {24'h0, IND_MATCH0});
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_INDIRECT_DATA, v);
            `CHK(v[7:0], m[8*i +: 8])
        end
        // alarm with auto reset, both routes and unmasked irq
        wr(ADDR_IRQ_MASK, 32'h1 << IRQ_ALARM);
        wr(ADDR_INDIRECT_ADDR, {24'h0, IND_CONTROL});
        wr(ADDR_INDIRECT_DATA, 32'h3B);
        wait_flag(1000, n);
        `CHK(flag, 1'b1)
        `CHK({a_rst, a_wake}, 2'b11)
        wait_flag(3000, n);
        `CHK(32'(n), m + 32'd2)
        rd(ADDR_IRQ_STATUS, v);
        `CHK(v[IRQ_ALARM], 1'b1)
        `CHK(irq, 1'b1)
        wr(ADDR_INDIRECT_ADDR, {24'h0, IND_CONTROL});
        wr(ADDR_INDIRECT_DATA, 32'h08);
        `CHK(flag, 1'b0)
        // disabled alarm stays quiet while the timer passes the match value
        wait_flag(1000, n);
        `CHK(flag, 1'b0)
        wr(ADDR_IRQ_STATUS, 32'h1 << IRQ_ALARM);
        rd(ADDR_IRQ_STATUS, v);
        `CHK({v[IRQ_ALARM], irq}, 2'b00)
        // every final code: ramp from the minimum, one step at a time
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_INDIRECT_ADDR, {24'h0, IND_XTAL_CFG});
            wr(ADDR_INDIRECT_DATA, 32'h10 | 32'(c));
            repeat (2) @(posedge clk);
            #1;
            `CHK(cap, CAP_MIN)
            prev = cap;
            n = 0;
            while (cap !== 4'(c) && n < 2000) begin
                @(posedge clk);
                #1;
                n++;
                `CHK((cap - prev) <= 4'h1, 1'b1)
                prev = cap;
            end
            `CHK(cap, 4'(c))
            rd(ADDR_INDIRECT_DATA, v);
            `CHK(v[7:0] & 8'h9F, 8'h90 | 8'(c))
        end
        // settled event masked, then unmasked, then cleared
        rd(ADDR_IRQ_STATUS, v);
        `CHK({v[IRQ_SETTLED], irq}, 2'b10)
        wr(ADDR_IRQ_MASK, 32'h3);
        rd(ADDR_IRQ_MASK, v);
        `CHK(v, 32'h3)
        `CHK(irq, 1'b1)
        wr(ADDR_IRQ_STATUS, 32'h1 << IRQ_SETTLED);
        rd(ADDR_IRQ_STATUS, v);
        `CHK({v[IRQ_SETTLED], irq}, 2'b00)
        tally_and_finish();
    end
endmodule : rac_top_tb
`undef CHK
`default_nettype wire
